// ==== design/mes_pkg.sv ====
// Constants, field layouts and state types of the metering signalling block.
// Assumes a 50 MHz system clock and a 32-bit APB register bus.
package mes_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ    = 50_000_000;
  localparam int SMP_HZ    = 5_000_000;
  localparam int SMP_DIV   = (CLK_HZ + SMP_HZ - 1) / SMP_HZ;
  localparam int IR_HZ     = 38_000;
  localparam int IR_HALF   = CLK_HZ / (2 * IR_HZ);
  localparam int MAX_SPS   = 4680;
  localparam int NCH       = 3;
  localparam int OSR_LIM   = 512;
  localparam int OSR_FLOOR = (SMP_HZ + NCH * MAX_SPS - 1) / (NCH * MAX_SPS);
  localparam int TGATE_US  = 1000;
  localparam int TGATE_CYC = CLK_HZ / 1_000_000 * TGATE_US;
  localparam int BUSY_CYC  = 2;
  // ****************************************
  // APB map
  // ****************************************
  localparam logic [15:0] A_CTRL  = 16'h0000;
  localparam logic [15:0] A_STAT  = 16'h0004;
  localparam logic [15:0] A_PEND  = 16'h0008;
  localparam logic [15:0] A_IRQEN = 16'h000c;
  localparam logic [15:0] A_ROUTE = 16'h0010;
  localparam logic [15:0] A_TTHR  = 16'h0014;
  localparam logic [15:0] A_TCNT  = 16'h0018;
  localparam logic [15:0] A_BAUD0 = 16'h001c;
  localparam logic [15:0] A_BAUD1 = 16'h0020;
  localparam logic [15:0] A_BAUD2 = 16'h0024;
  localparam logic [15:0] RAM_BASE = 16'h0c00;
  localparam logic [15:0] RAM_TOP  = 16'h13ff;
  // Control register bits
  localparam int C_RUN = 0;
  localparam int C_TEN = 1;
  localparam int C_WAKE = 2;
  localparam int C_IR = 3;
  // Pending bits
  localparam int P_BUSY = 0;
  localparam int P_XFER = 1;
  localparam int P_W = 2;
  localparam int P_V = 3;
  localparam int P_X = 4;
  localparam int P_Y = 5;
  localparam int P_TCH = 6;
  localparam int NPEND = 7;
  // ****************************************
  // Shared RAM word layout and engine control fields
  // ****************************************
  localparam logic [3:0] W_SMP_V = 4'h0;
  localparam logic [3:0] W_OUT0  = 4'h4;
  localparam logic [3:0] W_ECR   = 4'h8;
  localparam logic [3:0] W_PTHR  = 4'h9;
  localparam logic [3:0] W_SAG   = 4'ha;
  localparam int ECR_CNT = 0;
  localparam int ECR_OSR = 16;
  localparam int ECR_EQ = 26;
  localparam int ECR_GAIN = 27;
  localparam int ECR_DIFA = 29;
  localparam int ECR_DIFB = 30;
  // Input pin codes of the multiplexer
  localparam logic [2:0] PIN_CUR_A_POS = 3'h0;
  localparam logic [2:0] PIN_CUR_A_NEG = 3'h1;
  localparam logic [2:0] PIN_CUR_B_POS = 3'h2;
  localparam logic [2:0] PIN_LINE_V    = 3'h4;
  localparam logic [2:0] PIN_GND       = 3'h7;
  typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_PROC, ST_XFER} mes_st_t;
endpackage : mes_pkg

// ==== design/mes_rate.sv ====
// Programmable rate divider: one-cycle tick every div_in+1 clocks.
// Assumes div_in is steady or that a glitch of one period is acceptable.
`timescale 1ns/1ns
module mes_rate #(
  parameter int W = 16
) (
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] div_in,
  output logic              tick_out
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } mes_rate_t;
  mes_rate_t s_ff;
  mes_rate_t nxt_s;

  always_comb begin
    nxt_s      = s_ff;
    nxt_s.tick = 1'b0;
    if (s_ff.cnt >= div_in) begin
      nxt_s.cnt  = '0;
      nxt_s.tick = 1'b1;
    end else begin
      nxt_s.cnt = s_ff.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign tick_out = s_ff.tick;
endmodule : mes_rate

// ==== design/mes_sync.sv ====
// Two-stage synchroniser for one asynchronous level.
// Assumes the input may change at any time relative to clk_in.
`timescale 1ns/1ns
module mes_sync (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic d_in,
  output logic      q_out
);
  typedef struct packed {
    logic meta;
    logic q;
  } mes_sync_t;
  mes_sync_t s_ff;
  mes_sync_t nxt_s;

  always_comb begin
    nxt_s.meta = d_in;
    nxt_s.q    = s_ff.meta;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign q_out = s_ff.q;
endmodule : mes_sync

// ==== design/mes_top.sv ====
// Metering engine signalling: converter sequencing, energy sums, shared
// RAM, pulse outputs, touch detect and UART rate generation.
// Assumes an APB master on clk_in; converter bit and touch pin are async.
//
// How it works
// - Touch pin frequency below threshold raises alert
// - Touch alert optionally wakes the processor
// - Three UARTs, each own baud generator
// - UART zero transmit gets 38 kHz carrier
// - Five pins muxed into one converter
// - Inputs single-ended or paired differential
// - Channels: A pair, B pair sharing A minus, voltage
// - Converter samples at no more than 5 MHz
// - Decimation ratio programmable up to 512
// - At most 4.68 ksps per channel delivered
// - Engine, not host, sets converter configuration
// - Decimated samples written straight into engine RAM
// - Pair A preamp gain of 4, 8, 16
// - Instant values per pass, energies per interval
// - Sums of v*i, v squared, i squared
// - Equation 0 and equation 1 element products
// - Exchange through shared 32-bit register RAM
// - Output registers rewritten only after interval
// - Busy while processing; falling edge interrupts
// - Transfer flag while writing outputs; interrupts
// - Transfer after programmed sample count processed
// - Four pulses interrupt and route to pins
// - Shared RAM at processor bytes 0x0C00-0x13FF; only the first RW words answer, higher addresses in the range return an error
// - Both cores access RAM without wait states
// - Pulse X/Y pins not GPIO while running
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ns
module mes_top import mes_pkg::*; #(
  parameter int RW        = 16,
  parameter int TGATE     = TGATE_CYC,
  parameter int BAUD_W    = 16
) (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [15:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        adc_mod_in,
  input  wire logic        touch_osc_in,
  input  wire logic        uart0_txd_in,
  output logic      [2:0]  mux_pos_out,
  output logic      [2:0]  mux_neg_out,
  output logic             diff_en_out,
  output logic      [1:0]  preamp_gain_out,
  output logic             busy_out,
  output logic             result_transfer_flag_out,
  output logic             real_energy_pulse_out,
  output logic             reactive_energy_pulse_out,
  output logic             aux_event_pulse_x_out,
  output logic             aux_event_pulse_y_out,
  output logic      [3:0]  digital_io_pin_out,
  output logic             irq_out,
  output logic             wake_out,
  output logic      [2:0]  baud_tick_out,
  output logic             ir_tx_out
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    mes_st_t                  st;
    logic [3:0]               ctrl;
    logic [NPEND-1:0]         pend;
    logic [NPEND-1:0]         irqen;
    logic [5:0]               route;
    logic [15:0]              tthr;
    logic [15:0]              tcnt;
    logic [15:0]              tedge;
    logic [31:0]              tgate;
    logic                     tprev;
    logic [2:0][BAUD_W-1:0]   baud;
    logic [RW-1:0][31:0]      ram;
    logic [31:0]              prdata;
    logic                     pready;
    logic                     pslverr;
    logic [31:0]              ecr;
    logic [9:0]               osr;
    logic [9:0]               ocnt;
    logic [9:0]               ones;
    logic [1:0]               ch;
    logic [15:0]              scnt;
    logic [2:0][10:0]         smp;
    logic [1:0]               bcnt;
    logic [1:0]               xidx;
    logic [31:0]              acc0;
    logic [31:0]              acc1;
    logic [31:0]              vsq;
    logic [31:0]              isq;
    logic [31:0]              pacc0;
    logic [31:0]              pacc1;
    logic                     zc;
    logic                     vneg;
    logic                     busy;
    logic                     xfer;
    logic [3:0]               pulse;
    logic [3:0]               iopin;
    logic                     irq;
    logic                     wake;
    logic                     carrier;
    logic                     irtx;
    logic [2:0]               mpos;
    logic [2:0]               mneg;
    logic                     diff;
    logic [1:0]               gain;
  } mes_st_all_t;

  mes_st_all_t s_ff;
  mes_st_all_t nxt_s;

  logic adc_bit;
  logic tosc;
  logic smp_tick;
  logic ir_tick;
  logic [2:0] btick;

  mes_sync u_sync_adc (.clk_in(clk_in), .rst_n_in(rst_n_in),
                       .d_in(adc_mod_in), .q_out(adc_bit));
  mes_sync u_sync_tch (.clk_in(clk_in), .rst_n_in(rst_n_in),
                       .d_in(touch_osc_in), .q_out(tosc));

  // Sampling clock of the modulator, never above the limit
  mes_rate #(.W(8)) u_smp (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .div_in(8'(SMP_DIV - 1)), .tick_out(smp_tick));
  mes_rate #(.W(12)) u_ir (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .div_in(12'(IR_HALF - 1)), .tick_out(ir_tick));

  // ****************************************
  // UART rate generators
  // ****************************************
  for (genvar g = 0; g < 3; g++) begin : g_baud
    mes_rate #(.W(BAUD_W)) u_baud (.clk_in(clk_in),
      .rst_n_in(rst_n_in), .div_in(s_ff.baud[g]),
      .tick_out(btick[g]));
  end

  // ****************************************
  // Next state
  // ****************************************
  logic                setup;
  logic                wacc;
  logic [15:0]         roff;
  logic [8:0]          ridx;
  logic                ram_hit;
  logic [31:0]         rdata;
  logic                hit;
  logic [NPEND-1:0]    ev;
  logic [NPEND-1:0]    wclr;
  logic [9:0]          onew;
  logic signed [10:0]  sv;
  logic signed [10:0]  sa;
  logic signed [10:0]  sb;
  logic signed [11:0]  dab;
  logic signed [21:0]  p0;
  logic signed [21:0]  p1;
  logic [10:0]         vabs;
  logic [9:0]          osr_raw;

  always_comb begin
    nxt_s  = s_ff;
    ev     = '0;
    wclr   = '0;
    setup  = psel_in & ~penable_in;
    wacc   = psel_in & penable_in & s_ff.pready & pwrite_in;
    roff   = paddr_in - RAM_BASE;
    ridx   = roff[10:2];
    ram_hit = (paddr_in >= RAM_BASE) && (paddr_in <= RAM_TOP)
              && (32'(ridx) < RW);
    rdata  = '0;
    hit    = 1'b1;
    onew   = s_ff.ones + 10'(adc_bit);
    sv     = $signed(s_ff.smp[0]);
    sa     = $signed(s_ff.smp[1]);
    sb     = $signed(s_ff.smp[2]);
    dab    = (12'(sa) - 12'(sb)) >>> 1;
    p0     = '0;
    p1     = '0;
    vabs   = sv[10] ? 11'(-sv) : 11'(sv);
    osr_raw = s_ff.ecr[ECR_OSR +: 10];

    // APB: read data registered in setup, so access needs no wait
    unique case (paddr_in)
      A_CTRL:  rdata = 32'(s_ff.ctrl);
      A_STAT:  rdata = 32'({s_ff.st, s_ff.xfer, s_ff.busy});
      A_PEND:  rdata = 32'(s_ff.pend);
      A_IRQEN: rdata = 32'(s_ff.irqen);
      A_ROUTE: rdata = 32'(s_ff.route);
      A_TTHR:  rdata = 32'(s_ff.tthr);
      A_TCNT:  rdata = 32'(s_ff.tcnt);
      A_BAUD0: rdata = 32'(s_ff.baud[0]);
      A_BAUD1: rdata = 32'(s_ff.baud[1]);
      A_BAUD2: rdata = 32'(s_ff.baud[2]);
      default: begin
        hit   = ram_hit;
        rdata = ram_hit ? s_ff.ram[ridx] : '0;
      end
    endcase
    nxt_s.pready  = setup;
    nxt_s.prdata  = setup ? rdata : '0;
    nxt_s.pslverr = setup & ~hit;

    if (wacc && hit) begin
      unique case (paddr_in)
        A_CTRL:  nxt_s.ctrl = pwdata_in[3:0];
        A_PEND:  wclr = pwdata_in[NPEND-1:0];
        A_IRQEN: nxt_s.irqen = pwdata_in[NPEND-1:0];
        A_ROUTE: nxt_s.route = pwdata_in[5:0];
        A_TTHR:  nxt_s.tthr = pwdata_in[15:0];
        A_BAUD0: nxt_s.baud[0] = pwdata_in[BAUD_W-1:0];
        A_BAUD1: nxt_s.baud[1] = pwdata_in[BAUD_W-1:0];
        A_BAUD2: nxt_s.baud[2] = pwdata_in[BAUD_W-1:0];
        A_STAT, A_TCNT: ;
        // Host write lands in the same cycle as engine traffic
        default: nxt_s.ram[ridx] = pwdata_in;
      endcase
    end

    // ****************************************
    // Touch detect: edges counted over a fixed gate
    // ****************************************
    nxt_s.tprev = tosc;
    if (tosc && !s_ff.tprev && s_ff.tedge != 16'hffff) begin
      nxt_s.tedge = s_ff.tedge + 16'h0001;
    end
    if (s_ff.tgate >= 32'(TGATE - 1)) begin
      nxt_s.tgate = '0;
      nxt_s.tcnt  = nxt_s.tedge;
      nxt_s.tedge = '0;
      ev[P_TCH]   = s_ff.ctrl[C_TEN] && (nxt_s.tcnt < s_ff.tthr);
    end else begin
      nxt_s.tgate = s_ff.tgate + 32'h1;
    end

    // ****************************************
    // Engine sequencer
    // ****************************************
    nxt_s.busy = 1'b0;
    nxt_s.xfer = 1'b0;
    unique case (s_ff.st)
      ST_IDLE: begin
        // Configuration comes only from the engine's own RAM word
        if (s_ff.ctrl[C_RUN]) begin
          nxt_s.ecr = s_ff.ram[W_ECR];
          nxt_s.st  = ST_CONV;
          nxt_s.ch  = '0;
          nxt_s.ocnt = '0;
          nxt_s.ones = '0;
          osr_raw   = s_ff.ram[W_ECR][ECR_OSR +: 10];
          // Floor keeps per-channel rate under the limit
          if (osr_raw > 10'(OSR_LIM)) begin
            nxt_s.osr = 10'(OSR_LIM);
          end else if (osr_raw < 10'(OSR_FLOOR)) begin
            nxt_s.osr = 10'(OSR_FLOOR);
          end else begin
            nxt_s.osr = osr_raw;
          end
        end
      end
      ST_CONV: begin
        if (smp_tick) begin
          nxt_s.ones = onew;
          nxt_s.ocnt = s_ff.ocnt + 10'h001;
          if (s_ff.ocnt == s_ff.osr - 10'h001) begin
            nxt_s.smp[s_ff.ch] = 11'({onew, 1'b0}) - 11'(s_ff.osr);
            nxt_s.ram[W_SMP_V + 4'(s_ff.ch)] =
              32'($signed(nxt_s.smp[s_ff.ch]));
            nxt_s.ocnt = '0;
            nxt_s.ones = '0;
            if (s_ff.ch == 2'h2) begin
              nxt_s.st   = ST_PROC;
              nxt_s.bcnt = '0;
              nxt_s.busy = 1'b1;
            end else begin
              nxt_s.ch = s_ff.ch + 2'h1;
            end
          end
        end
      end
      ST_PROC: begin
        nxt_s.busy = 1'b1;
        nxt_s.bcnt = s_ff.bcnt + 2'h1;
        if (s_ff.bcnt == '0) begin
          if (s_ff.ecr[ECR_EQ]) begin
            p0 = 22'(sv * dab);
          end else begin
            p0 = sv * sa;
            p1 = sv * sb;
          end
          nxt_s.acc0 = s_ff.acc0 + 32'(p0);
          nxt_s.acc1 = s_ff.acc1 + 32'(p1);
          nxt_s.vsq  = s_ff.vsq + 32'(sv * sv);
          nxt_s.isq  = s_ff.isq + 32'(sa * sa);
          // Instant values: pulses and sag follow every pass
          nxt_s.pulse = '0;
          nxt_s.pacc0 = (p0 > 0) ? s_ff.pacc0 + 32'(p0) : s_ff.pacc0;
          nxt_s.pacc1 = (p1 > 0) ? s_ff.pacc1 + 32'(p1) : s_ff.pacc1;
          if (s_ff.ram[W_PTHR] != '0 && nxt_s.pacc0 >= s_ff.ram[W_PTHR]) begin
            nxt_s.pacc0    = nxt_s.pacc0 - s_ff.ram[W_PTHR];
            nxt_s.pulse[0] = 1'b1;
          end
          if (s_ff.ram[W_PTHR] != '0 && nxt_s.pacc1 >= s_ff.ram[W_PTHR]) begin
            nxt_s.pacc1    = nxt_s.pacc1 - s_ff.ram[W_PTHR];
            nxt_s.pulse[1] = 1'b1;
          end
          nxt_s.pulse[2] = 32'(vabs) < s_ff.ram[W_SAG];
          nxt_s.vneg = sv[10];
          if (sv[10] != s_ff.vneg) begin
            nxt_s.zc = 1'b1;
          end
        end
        if (s_ff.bcnt == 2'(BUSY_CYC - 1)) begin
          nxt_s.busy = 1'b0;
          nxt_s.scnt = s_ff.scnt + 16'h0001;
          nxt_s.ch   = '0;
          if (s_ff.scnt + 16'h0001 >= s_ff.ecr[ECR_CNT +: 16]) begin
            nxt_s.st   = ST_XFER;
            nxt_s.xidx = '0;
            nxt_s.xfer = 1'b1;
          end else begin
            nxt_s.st = ST_CONV;
          end
        end
      end
      ST_XFER: begin
        nxt_s.xfer = 1'b1;
        nxt_s.xidx = s_ff.xidx + 2'h1;
        // Output words change only here and on host writes
        unique case (s_ff.xidx)
          2'h0: nxt_s.ram[W_OUT0] = s_ff.acc0;
          2'h1: nxt_s.ram[W_OUT0 + 4'h1] = s_ff.acc1;
          2'h2: nxt_s.ram[W_OUT0 + 4'h2] = s_ff.vsq;
          2'h3: begin
            nxt_s.ram[W_OUT0 + 4'h3] = s_ff.isq;
            nxt_s.xfer     = 1'b0;
            nxt_s.pulse[3] = ~s_ff.zc;
            nxt_s.zc   = 1'b0;
            nxt_s.acc0 = '0;
            nxt_s.acc1 = '0;
            nxt_s.vsq  = '0;
            nxt_s.isq  = '0;
            nxt_s.scnt = '0;
            nxt_s.st   = ST_IDLE;
          end
        endcase
      end
    endcase
    // Stopping the engine resets the sample count but keeps the sums; outputs stay as last written
    if (!s_ff.ctrl[C_RUN]) begin
      nxt_s.st   = ST_IDLE;
      nxt_s.busy = 1'b0;
      nxt_s.xfer = 1'b0;
      nxt_s.scnt = '0;
    end

    // ****************************************
    // Converter pins for the next channel
    // ****************************************
    nxt_s.mpos = PIN_LINE_V;
    nxt_s.mneg = PIN_GND;
    nxt_s.diff = 1'b0;
    nxt_s.gain = 2'h0;
    if (nxt_s.ch == 2'h1) begin
      nxt_s.mpos = PIN_CUR_A_POS;
      nxt_s.diff = nxt_s.ecr[ECR_DIFA];
      nxt_s.mneg = nxt_s.diff ? PIN_CUR_A_NEG : PIN_GND;
      nxt_s.gain = nxt_s.diff ? nxt_s.ecr[ECR_GAIN +: 2] : 2'h0;
    end else if (nxt_s.ch == 2'h2) begin
      nxt_s.mpos = PIN_CUR_B_POS;
      nxt_s.diff = nxt_s.ecr[ECR_DIFB];
      nxt_s.mneg = nxt_s.diff ? PIN_CUR_A_NEG : PIN_GND;
    end

    // ****************************************
    // Events, pending flags, pins
    // ****************************************
    ev[P_BUSY] = s_ff.busy & ~nxt_s.busy;
    ev[P_XFER] = ~s_ff.xfer & nxt_s.xfer;
    ev[P_W]    = nxt_s.pulse[0] & ~s_ff.pulse[0];
    ev[P_V]    = nxt_s.pulse[1] & ~s_ff.pulse[1];
    ev[P_X]    = nxt_s.pulse[2] & ~s_ff.pulse[2];
    ev[P_Y]    = nxt_s.pulse[3] & ~s_ff.pulse[3];
    // A new event beats a clear in the same cycle
    nxt_s.pend = (s_ff.pend & ~wclr) | ev;
    nxt_s.irq  = |(nxt_s.pend & nxt_s.irqen);
    nxt_s.wake = nxt_s.ctrl[C_WAKE] & nxt_s.pend[P_TCH];
    for (int i = 0; i < 4; i++) begin
      nxt_s.iopin[i] = nxt_s.route[i] & nxt_s.pulse[i];
    end
    if (!nxt_s.ctrl[C_RUN]) begin
      nxt_s.iopin[2] = nxt_s.route[4];
      nxt_s.iopin[3] = nxt_s.route[5];
    end
    if (ir_tick) begin
      nxt_s.carrier = ~s_ff.carrier;
    end
    nxt_s.irtx = nxt_s.ctrl[C_IR] & ~uart0_txd_in & nxt_s.carrier;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata_out                = s_ff.prdata;
  assign pready_out                = s_ff.pready;
  assign pslverr_out               = s_ff.pslverr;
  assign mux_pos_out               = s_ff.mpos;
  assign mux_neg_out               = s_ff.mneg;
  assign diff_en_out               = s_ff.diff;
  assign preamp_gain_out           = s_ff.gain;
  assign busy_out                  = s_ff.busy;
  assign result_transfer_flag_out  = s_ff.xfer;
  assign real_energy_pulse_out     = s_ff.pulse[0];
  assign reactive_energy_pulse_out = s_ff.pulse[1];
  assign aux_event_pulse_x_out     = s_ff.pulse[2];
  assign aux_event_pulse_y_out     = s_ff.pulse[3];
  assign digital_io_pin_out        = s_ff.iopin;
  assign irq_out                   = s_ff.irq;
  assign wake_out                  = s_ff.wake;
  assign baud_tick_out             = btick;
  assign ir_tx_out                 = s_ff.irtx;
endmodule : mes_top

// ==== tb/mes_front_model.sv ====
// Far side stand-in: converter bitstream and touch pad oscillator.
// Assumes the bench clock; the pad oscillates only while sensing is on.
`timescale 1ns/1ns
module mes_front_model (
  input  wire logic clk_in,
  input  wire logic touch_en_in,
  output logic      adc_mod_out,
  output logic      touch_osc_out
);
  logic [3:0] n = 4'h0;
  // Full scale, so every decimated sample reads +osr
  initial adc_mod_out = 1'b1;
  initial touch_osc_out = 1'b0;
  // Slow pad, 16 clocks a period: stands for a loaded, touched pin
  always @(posedge clk_in) begin
    n <= touch_en_in ? n + 4'h1 : 4'h0;
    touch_osc_out <= touch_en_in & n[3];
  end
endmodule : mes_front_model

// ==== tb/mes_monitor.sv ====
// Checker on mes_top pins: bus answer, flag lengths, pin relations.
// Assumes binding into mes_top; one clock, reset active low.
`timescale 1ns/1ns
module mes_monitor import mes_pkg::*; (
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        uart0_txd_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        diff_en_out,
  input wire logic [1:0]  preamp_gain_out,
  input wire logic [2:0]  mux_pos_out,
  input wire logic [2:0]  mux_neg_out,
  input wire logic        busy_out,
  input wire logic        result_transfer_flag_out,
  input wire logic        ir_tx_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  no_wait_a: assert property (
    psel_in && !penable_in |=> pready_out) else $error("late answer");
  ans_cause_a: assert property (
    pready_out |-> $past(psel_in) && !$past(penable_in))
    else $error("stray ready");
  err_ready_a: assert property (
    pslverr_out |-> pready_out) else $error("error without ready");
  rd_idle_a: assert property (
    !pready_out |-> prdata_out == 32'h0) else $error("data outside access");
  busy_len_a: assert property (
    $rose(busy_out) |-> busy_out [*2] ##1 !busy_out)
    else $error("busy length");
  xfer_len_a: assert property (
    $rose(result_transfer_flag_out) |-> result_transfer_flag_out [*4]
    ##1 !result_transfer_flag_out) else $error("transfer length");
  xfer_excl_a: assert property (
    result_transfer_flag_out |-> !busy_out) else $error("busy in transfer");
  ir_gate_a: assert property (
    ir_tx_out |-> !$past(uart0_txd_in)) else $error("carrier while idle");
  gain_diff_a: assert property (
    preamp_gain_out != 2'h0 |-> diff_en_out) else $error("gain single");
  diff_neg_a: assert property (
    diff_en_out |-> mux_neg_out == PIN_CUR_A_NEG)
    else $error("pair without shared minus");
  gain_pin_a: assert property (
    preamp_gain_out != 2'h0 |-> mux_pos_out == PIN_CUR_A_POS)
    else $error("gain outside pair A");
endmodule : mes_monitor
bind mes_top mes_monitor u_mon (.clk_in, .rst_n_in, .psel_in, .penable_in,
  .uart0_txd_in, .prdata_out, .pready_out, .pslverr_out, .mux_pos_out,
  .mux_neg_out, .diff_en_out, .preamp_gain_out, .busy_out,
  .result_transfer_flag_out, .ir_tx_out);

// ==== tb/tb_top.sv ====
// Self-checking bench for mes_top: APB master, queue scoreboard.
// Assumes mes_front_model feeds the converter and touch pins.
`timescale 1ns/1ns
module tb_top import mes_pkg::*;;
  localparam int OSR = 357;
  localparam int NS = 2;
  logic        clk_in = 0, rst_n_in = 0, psel = 0, pen = 0, pwr = 0;
  logic        txd = 1, ten = 0, hi = 0;
  logic [15:0] pa = '0;
  logic [31:0] pwd = '0, prd, r;
  logic [32:0] e, q[$];
  logic        pr, pe, busy, xf, irq, wake, ir, mod, osc;
  int          bad_count = 0, total_checks = 0, seed = 98;
  always #10 clk_in = ~clk_in;
  mes_top #(.TGATE(64)) u_dut (.clk_in, .rst_n_in, .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd),
    .prdata_out(prd), .pready_out(pr), .pslverr_out(pe), .adc_mod_in(mod),
    .touch_osc_in(osc), .uart0_txd_in(txd), .mux_pos_out(), .mux_neg_out(),
    .diff_en_out(), .preamp_gain_out(), .busy_out(busy),
    .result_transfer_flag_out(xf), .real_energy_pulse_out(),
    .reactive_energy_pulse_out(), .aux_event_pulse_x_out(),
    .aux_event_pulse_y_out(), .digital_io_pin_out(), .irq_out(irq),
    .wake_out(wake), .baud_tick_out(), .ir_tx_out(ir));
  mes_front_model u_fe (.clk_in, .touch_en_in(ten), .adc_mod_out(mod),
    .touch_osc_out(osc));
  task automatic finish_test;
    if (bad_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [15:0] a,
                     input logic [31:0] d, input logic [32:0] x);
    @(posedge clk_in);
    q.push_back(x);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk_in);
    pen <= 1'b1;
    do @(posedge clk_in); while (pr !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [31:0] d);
    apb(1'b0, a, 32'h0, {1'b0, d});
  endtask : rd
  // Scoreboard: oldest note is the answer to the transfer now ending
  always @(posedge clk_in) begin
    if (psel && pen && pr === 1'b1) begin
      e = q.pop_front();
      chk("pslverr", 32'(pe), 32'(e[32]));
      if (!pwr) chk("prdata", prd, e[31:0]);
    end
  end
  initial begin
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd(A_PEND, 32'h0);
    apb(1'b0, 16'h0028, 32'h0, {1'b1, 32'h0});
    apb(1'b1, RAM_BASE + 16'h0040, 32'h1, {1'b1, 32'h0});
    r = $random(seed);
    wr(RAM_BASE + 16'h000c, r);
    rd(RAM_BASE + 16'h000c, r);
    for (int k = 4; k < 11; k++)
      if (k != 8) wr(RAM_BASE + 16'(4 * k), 32'h0);
    // Program loaded before the engine is released
    wr(RAM_BASE + 16'h0020, {3'b011, 2'h2, 1'b0, 10'(OSR), 16'(NS)});
    wr(A_IRQEN, 32'h2);
    wr(A_CTRL, 32'h1);
    wait (busy === 1'b1);
    wait (busy === 1'b0);
    rd(RAM_BASE + 16'h0010, 32'h0);
    wait (xf === 1'b1);
    wait (xf === 1'b0);
    for (int k = 4; k < 8; k++)
      rd(RAM_BASE + 16'(4 * k), 32'(OSR * OSR * NS));
    @(posedge clk_in);
    chk("irq", 32'(irq), 32'h1);
    wr(RAM_BASE + 16'h0020, {3'b011, 2'h2, 1'b1, 10'(OSR), 16'(NS)});
    repeat (2) begin
      wait (xf === 1'b1);
      wait (xf === 1'b0);
    end
    rd(RAM_BASE + 16'h0010, 32'h0);
    wr(A_CTRL, 32'h0);
    rd(A_PEND, 32'h23);
    wr(A_PEND, 32'h7f);
    rd(A_PEND, 32'h0);
    ten <= 1'b1;
    txd <= 1'b0;
    // Pad runs ahead of the first enabled gate, so every gate sees 4 edges
    wr(A_TTHR, 32'd2);
    repeat (100) @(posedge clk_in);
    wr(A_CTRL, 32'he);
    repeat (200) @(posedge clk_in);
    rd(A_PEND, 32'h0);
    wr(A_TTHR, 32'd100);
    repeat (1400) begin
      @(posedge clk_in);
      hi = hi | ir;
    end
    chk("ir_tx", 32'(hi), 32'h1);
    chk("wake", 32'(wake), 32'h1);
    rd(A_PEND, 32'h40);
    finish_test();
  end
  initial begin
    #3_000_000;
    bad_count++;
    finish_test();
  end
endmodule : tb_top
